// [hw/btt_cfg.svh]
/*
Holds the offsets, field positions, control reset value and divider figures of the tick timer.
Assumes it is included once per compile unit by its bare name.
*/
`ifndef BTT_CFG_SVH
`define BTT_CFG_SVH
`define BTT_CTRL_ADDR 8'hD3
`define BTT_COUNT_ADDR 8'hFD
`define BTT_CTRL_RESET 8'h00
`define BTT_WD_OFF_CODE 4'hA
`define BTT_SIG_HI 7
`define BTT_SIG_LO 4
`define BTT_SEL_HI 3
`define BTT_SEL_LO 2
`define BTT_CNT_CLR_BIT 1
`define BTT_DIV_CLR_BIT 0
`define BTT_SEL_4096 2'h0
`define BTT_SEL_1024 2'h1
`define BTT_SEL_128 2'h3
`define BTT_DIV_W 12
`define BTT_TAP_4096 11
`define BTT_TAP_1024 9
`define BTT_TAP_128 6
`define BTT_STAB_BIT 4
`endif

// [hw/btt_pkg.sv]
/*
Holds the types shared by the tick timer files.
Assumes the configuration header supplies the numeric figures.
*/
package btt_pkg;
  typedef enum logic [2:0]
  {
    BTT_RUN = 3'b001,
    BTT_STAB_RESET = 3'b010,
    BTT_STAB_IRQ = 3'b100
  } btt_mode_t;
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } btt_bus_t;
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [11:0] div;
    logic [11:0] div_prev;
    logic [7:0] rdata;
    logic wd_reset;
    logic stab_done;
    logic cpu_clk_en;
    btt_mode_t mode;
  } btt_state_t;
endpackage

// [hw/btt_prescaler.sv]
/*
Holds the free-running prescaler whose divider stages the tick timer taps for its tick enables.
Assumes one clock and a synchronous active-high clear.
*/
module btt_prescaler
  import btt_pkg::*;
(
  // Clock and clear.
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  // Divider stages.
  output logic [11:0] div
);
  logic [11:0] next_div;

  always_comb
  begin
    next_div = div + 12'h001;
    if (clear)
    begin
      next_div = 12'h000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div <= 12'h000;
    end
    else
    begin
      div <= next_div;
    end
  end
endmodule

// [hw/btt_timer.sv]
/*
Holds the tick timer: prescaler tap selection, 8-bit counter, watchdog and stabilization interval.
Assumes a CPU register port on the system clock and an external Stop-mode wake request.
*/
module btt_timer
  import btt_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic SRST,
  // Register port.
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Stop mode.
  input wire logic STOP_WAKE_IRQ,
  // Chip control.
  output logic WD_RESET,
  output logic STAB_DONE,
  output logic CPU_CLK_EN
);
  `include "btt_cfg.svh"

  btt_state_t st;
  btt_state_t next_st;
  btt_bus_t bus;
  logic [11:0] div;
  logic div_clear;
  logic tick;
  logic wake_s1;
  logic wake_s2;
  logic wake_s3;

  function automatic logic tap_edge(input logic [11:0] cur, input logic [11:0] prv,
                                    input logic [1:0] sel);
    logic [11:0] fall;
    fall = prv & ~cur;
    unique case (sel)
      `BTT_SEL_1024: tap_edge = fall[`BTT_TAP_1024];
      `BTT_SEL_128: tap_edge = fall[`BTT_TAP_128];
      default: tap_edge = fall[`BTT_TAP_4096];
    endcase
  endfunction

  assign bus = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
  assign div_clear = bus.wr && bus.addr == `BTT_CTRL_ADDR && bus.wdata[`BTT_DIV_CLR_BIT];

  btt_prescaler u_prescaler
  (
    .clk(REF_CLK),
    .srst(SRST),
    .clear(div_clear),
    .div(div)
  );

  always_ff @(posedge REF_CLK)
  begin
    wake_s1 <= STOP_WAKE_IRQ;
    wake_s2 <= wake_s1;
    wake_s3 <= wake_s2;
  end

  always_comb
  begin
    next_st = st;
    next_st.div = div;
    next_st.div_prev = div;
    if (div_clear)
    begin
      // The divider restarts from zero, so the drop of its old value must not count as a tick.
      next_st.div_prev = 12'h000;
    end
    next_st.wd_reset = 1'b0;
    next_st.stab_done = 1'b0;
    if (st.mode == BTT_STAB_RESET)
    begin
      tick = tap_edge(div, st.div_prev, `BTT_SEL_4096);
    end
    else
    begin
      tick = tap_edge(div, st.div_prev, st.ctrl[`BTT_SEL_HI:`BTT_SEL_LO]);
    end
    if (tick)
    begin
      next_st.count = st.count + 8'h01;
      if (st.mode != BTT_RUN && st.count[`BTT_STAB_BIT:0] == 5'h1F)
      begin
        next_st.mode = BTT_RUN;
        next_st.stab_done = 1'b1;
        next_st.cpu_clk_en = 1'b1;
      end
      if (st.mode == BTT_RUN && st.count == 8'hFF
          && st.ctrl[`BTT_SIG_HI:`BTT_SIG_LO] != `BTT_WD_OFF_CODE)
      begin
        next_st.wd_reset = 1'b1;
      end
    end
    if (wake_s2 && !wake_s3 && st.mode == BTT_RUN)
    begin
      next_st.mode = BTT_STAB_IRQ;
      next_st.cpu_clk_en = 1'b0;
      next_st.count = 8'h00;
    end
    if (bus.wr && bus.addr == `BTT_CTRL_ADDR)
    begin
      next_st.ctrl = {bus.wdata[7:2], 2'b00};
      if (bus.wdata[`BTT_CNT_CLR_BIT])
      begin
        next_st.count = 8'h00;
      end
    end
    next_st.rdata = st.rdata;
    if (bus.rd)
    begin
      if (bus.addr == `BTT_CTRL_ADDR)
      begin
        next_st.rdata = st.ctrl;
      end
      else if (bus.addr == `BTT_COUNT_ADDR)
      begin
        next_st.rdata = st.count;
      end
      else
      begin
        next_st.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      st.ctrl <= `BTT_CTRL_RESET;
      st.count <= 8'h00;
      st.div <= 12'h000;
      st.div_prev <= 12'h000;
      st.rdata <= 8'h00;
      st.wd_reset <= 1'b0;
      st.stab_done <= 1'b0;
      st.cpu_clk_en <= 1'b0;
      st.mode <= BTT_STAB_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign REG_RDATA = st.rdata;
  assign WD_RESET = st.wd_reset;
  assign STAB_DONE = st.stab_done;
  assign CPU_CLK_EN = st.cpu_clk_en;
endmodule

// [verification/btt_props.sv]
/*
Port checker of the tick timer.
Assumes a bind onto btt_timer.
*/
module btt_props (
  // Watched ports.
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic STOP_WAKE_IRQ,
  input wire logic WD_RESET,
  input wire logic STAB_DONE,
  input wire logic CPU_CLK_EN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sequence s_clr;
    REG_WR && REG_ADDR == 8'hd3 && REG_WDATA[1] ##1 REG_RD && REG_ADDR == 8'hfd;
  endsequence
  property p_clr; s_clr |=> REG_RDATA == 8'h00; endproperty
  property p_wdp; WD_RESET |=> !WD_RESET; endproperty
  property p_wdr; WD_RESET |-> $past(CPU_CLK_EN); endproperty
  property p_sdp; STAB_DONE |=> !STAB_DONE; endproperty
  property p_sde; STAB_DONE |-> CPU_CLK_EN && !$past(CPU_CLK_EN); endproperty
  property p_ris; $rose(CPU_CLK_EN) |-> STAB_DONE; endproperty
  property p_rd; REG_RD && REG_ADDR == 8'hd3 |=> REG_RDATA[1:0] == 2'h0; endproperty
  property p_wak; $rose(STOP_WAKE_IRQ) && CPU_CLK_EN |-> ##[1:4] !CPU_CLK_EN; endproperty
  a_clr: assert property (p_clr) else $error("count clear");
  a_wdp: assert property (p_wdp) else $error("reset pulse");
  a_wdr: assert property (p_wdr) else $error("reset in wait");
  a_sdp: assert property (p_sdp) else $error("done pulse");
  a_sde: assert property (p_sde) else $error("done gate");
  a_ris: assert property (p_ris) else $error("gate rise");
  a_rd: assert property (p_rd) else $error("clear bits");
  a_wak: assert property (p_wak) else $error("wake gate");
endmodule
bind btt_timer btt_props u_props (.REF_CLK, .SRST, .REG_WR, .REG_RD, .REG_ADDR,
  .REG_WDATA, .REG_RDATA, .STOP_WAKE_IRQ, .WD_RESET, .STAB_DONE, .CPU_CLK_EN);

// [verification/btt_timer_tb.sv]
/*
Bench of the tick timer.
Assumes the design and checker are compiled first.
*/
module btt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 0, SRST = 1, REG_WR = 0, REG_RD = 0, STOP_WAKE_IRQ = 0;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, r;
  logic WD_RESET, STAB_DONE, CPU_CLK_EN;
  int err_total = 0, compares = 0, wd = 0, sd = 0, cyc = 0, n;
  logic [7:0] cw[3] = '{8'haf, 8'ha7, 8'ha3};
  int dv[3] = '{128, 1024, 4096};
  always #2.5 REF_CLK = ~REF_CLK;
  btt_timer DUT (.REF_CLK, .SRST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .STOP_WAKE_IRQ, .WD_RESET, .STAB_DONE, .CPU_CLK_EN);
  function automatic logic [7:0] fx(logic [7:0] d);
    return d & 8'hfc;
  endfunction
  task automatic end_of_test;
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge REF_CLK);
    REG_WR <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge REF_CLK);
    REG_WR <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    REG_RD <= 1;
    REG_ADDR <= a;
    @(posedge REF_CLK);
    REG_RD <= 0;
    @(negedge REF_CLK);
    chk("rdata", e, REG_RDATA);
    @(posedge REF_CLK);
  endtask
  task automatic ev(input int t);
    n = wd + sd;
    repeat (t) if (wd + sd == n) @(posedge REF_CLK);
  endtask
  always @(negedge REF_CLK)
  begin
    cyc++;
    wd += int'(WD_RESET === 1'b1);
    sd += int'(STAB_DONE === 1'b1);
    if (cyc == 300000)
    begin
      err_total++;
      end_of_test;
    end
  end
  initial
  begin
    void'($urandom(32'h90cd));
    repeat (12) @(posedge REF_CLK);
    SRST <= 0;
    rd(8'hd3, 8'h00);
    ev(140000);
    chk("done", 8'h01, 8'(sd));
    rd(8'hfd, 8'h20);
    rd(8'h10, 8'h00);
    wr(8'hd3, 8'haf);
    rd(8'hfd, 8'h00);
    wr(8'hfd, 8'h77);
    rd(8'hfd, 8'h00);
    rd(8'hd3, 8'hac);
    foreach (dv[i])
    begin
      wr(8'hd3, cw[i]);
      repeat (dv[i] * 3 + dv[i] / 2) @(posedge REF_CLK);
      rd(8'hfd, 8'h03);
    end
    wr(8'hd3, 8'haf);
    ev(34000);
    chk("wd", 8'h00, 8'(wd));
    repeat (4)
    begin
      r = 8'($urandom);
      r[7] = r[7:4] == 4'ha ? 1'b0 : r[7];
      wr(8'hd3, r);
      rd(8'hd3, fx(r));
    end
    repeat (2)
    begin
      wr(8'hd3, 8'h0e);
      repeat (17000) @(posedge REF_CLK);
    end
    chk("wd", 8'h00, 8'(wd));
    wr(8'hd3, 8'h0f);
    ev(34000);
    chk("wd", 8'h01, 8'(wd));
    rd(8'hfd, 8'h00);
    @(posedge REF_CLK);
    STOP_WAKE_IRQ <= 1;
    ev(6000);
    chk("done", 8'h02, 8'(sd));
    rd(8'hfd, 8'h20);
    end_of_test;
  end
endmodule
